/* File: logic/blpd_driver.sv */
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ns
`include "blpd_cfg.svh"

module blpd_driver
    import blpd_pkg::*;
(
    input  wire logic          sys_clk_in,
    input  wire logic          resetn_in,
    input  wire blpd_apb_req_t apb_req_in,
    input  wire logic          backlight_option_in,
    input  wire logic          base_clock_in,
    output blpd_apb_rsp_t      apb_rsp_out,
    output logic               pump_clock_out,
    output logic               discharge_pulse_out,
    output logic               port_select_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers and register file.

    logic                          option_meta;
    logic                          option_sync;
    logic                          base_meta;
    logic                          base_sync;
    logic                          base_prev;
    logic [`BLPD_CFG_WIDTH-1:0]    cfg_word;
    logic                          light_enable_flag;
    blpd_state_t                   state;
    logic                          apb_access;

    // Pin-level option and external base clock cross two flops before use.
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            option_meta <= 1'b0;
            option_sync <= 1'b0;
            base_meta   <= 1'b0;
            base_sync   <= 1'b0;
            base_prev   <= 1'b0;
        end else begin
            option_meta <= backlight_option_in;
            option_sync <= option_meta;
            base_meta   <= base_clock_in;
            base_sync   <= base_meta;
            base_prev   <= base_sync;
        end
    end

    assign apb_access = apb_req_in.psel && apb_req_in.penable;

    // Configuration writes; the waveform logic latches them at period ends.
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg_word <= `BLPD_CFG_RESET;
        end else if (apb_access && apb_req_in.pwrite && apb_req_in.paddr == `BLPD_ADDR_CONFIG) begin
            cfg_word <= apb_req_in.pwdata[`BLPD_CFG_WIDTH-1:0];
        end
    end

    // Flag set/reset only act when the operand addresses the light flag.
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            light_enable_flag <= 1'b0;
        end else if (apb_access && apb_req_in.pwrite &&
                     apb_req_in.pwdata[3:0] == `BLPD_LIGHT_OPERAND) begin
            if (apb_req_in.paddr == `BLPD_ADDR_FLAG_SET) begin
                light_enable_flag <= 1'b1;
            end else if (apb_req_in.paddr == `BLPD_ADDR_FLAG_RESET) begin
                light_enable_flag <= 1'b0;
            end
        end
    end

    // Zero-wait APB answer; unmapped addresses return an error.
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            apb_rsp_out <= '0;
        end else begin
            apb_rsp_out.pready  <= apb_req_in.psel && !apb_req_in.penable;
            apb_rsp_out.pslverr <= 1'b0;
            apb_rsp_out.prdata  <= 32'h0000_0000;
            if (apb_req_in.psel && !apb_req_in.penable) begin
                unique case (apb_req_in.paddr)
                    `BLPD_ADDR_CONFIG:
                        apb_rsp_out.prdata <= {23'h000000, cfg_word};
                    `BLPD_ADDR_FLAG_SET, `BLPD_ADDR_FLAG_RESET:
                        apb_rsp_out.prdata <= 32'h0000_0000;
                    `BLPD_ADDR_STATUS:
                        apb_rsp_out.prdata <= {26'h0000000, option_sync, light_enable_flag, state};
                    default:
                        apb_rsp_out.pslverr <= 1'b1;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pre-divider and rate enables.

    logic [`BLPD_PREDIV_WIDTH-1:0] prediv;
    logic [`BLPD_PREDIV_WIDTH-1:0] prediv_next_val;
    logic [`BLPD_PREDIV_WIDTH-1:0] tap_tick;
    logic                          base_tick;
    logic [2:0]                    base_div;
    logic                          pump_tick;
    logic                          dis_tick;
    blpd_cfg_t                     pump_cfg;
    blpd_cfg_t                     live_cfg;

    assign live_cfg = blpd_cfg_t'(cfg_word);

    // Free-running pre-divider counter.
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            prediv <= '0;
        end else begin
            prediv <= prediv_next_val;
        end
    end

    assign prediv_next_val = prediv + `BLPD_PREDIV_WIDTH'(1);

    // Tap N enable pulses once per 2^(N+1) cycles, on the carry out of bit N.
    genvar gi;
    generate
        for (gi = 0; gi < `BLPD_PREDIV_WIDTH; gi++) begin : g_tap
            assign tap_tick[gi] = prediv[gi] && !prediv_next_val[gi];
        end
    endgenerate

    // Base clock rising edges, further divided for the slower pump settings.
    assign base_tick = base_sync && !base_prev;

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            base_div <= 3'h0;
        end else if (base_tick) begin
            base_div <= base_div + 3'h1;
        end
    end

    // Pump rate select from the latched settings.
    always_comb begin
        unique case (pump_cfg.pump_freq)
            `BLPD_PF_BASE:      pump_tick = base_tick;
            `BLPD_PF_BASE_DIV2: pump_tick = base_tick && base_div[0];
            `BLPD_PF_BASE_DIV4: pump_tick = base_tick && (base_div[1:0] == 2'h3);
            `BLPD_PF_BASE_DIV8: pump_tick = base_tick && (base_div == 3'h7);
            default:            pump_tick = tap_tick[0];
        endcase
    end

    // Discharge rate: code 0 is tap 8 down to code 3 at tap 5.
    always_comb begin
        unique case (pump_cfg.dis_rate)
            2'h0: dis_tick = tap_tick[8];
            2'h1: dis_tick = tap_tick[7];
            2'h2: dis_tick = tap_tick[6];
            2'h3: dis_tick = tap_tick[5];
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Waveform shaping. Each period is twelve sub-steps so 1/4, 1/3, 1/2
    // and full duty all land on whole steps; each selected tick advances the
    // phase counter by one sub-step, so a period spans twelve ticks.

    logic [3:0] pump_phase;
    logic [3:0] dis_phase;
    logic       pump_level;
    logic       dis_level;
    logic       pump_wrap;
    logic       dis_wrap;

    // Duty threshold in twelfths for a two-bit duty code.
    function automatic logic [3:0] duty_steps(input logic [1:0] code);
        unique case (code)
            `BLPD_DUTY_QUARTER: duty_steps = 4'h3;
            `BLPD_DUTY_THIRD:   duty_steps = 4'h4;
            `BLPD_DUTY_HALF:    duty_steps = 4'h6;
            `BLPD_DUTY_FULL:    duty_steps = 4'hC;
        endcase
    endfunction

    assign pump_wrap = pump_tick && (pump_phase == 4'hB);
    assign dis_wrap  = dis_tick && (dis_phase == 4'hB);

    // Settings are sampled only at a pump or discharge period boundary or while idle.
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pump_cfg <= blpd_cfg_t'(`BLPD_CFG_RESET);
        end else if (state == BLPD_IDLE || pump_wrap || dis_wrap) begin
            pump_cfg <= live_cfg;
        end
    end

    // Pump phase counter; restarts whenever pumping is not allowed.
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pump_phase <= 4'h0;
        end else if (state != BLPD_PUMP) begin
            pump_phase <= 4'h0;
        end else if (pump_tick) begin
            pump_phase <= pump_wrap ? 4'h0 : pump_phase + 4'h1;
        end
    end

    // Discharge phase counter; runs only during a discharge state.
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dis_phase <= 4'h0;
        end else if (state != BLPD_PRE_DIS && state != BLPD_POST_DIS) begin
            dis_phase <= 4'h0;
        end else if (dis_tick) begin
            dis_phase <= dis_wrap ? 4'h0 : dis_phase + 4'h1;
        end
    end

    assign pump_level = (pump_phase < duty_steps(pump_cfg.pump_duty));
    assign dis_level  = (dis_phase < duty_steps(pump_cfg.dis_duty));

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: idle, discharge, pump, discharge, idle.

    blpd_state_t next_state;

    always_comb begin
        next_state = state;
        unique case (state)
            // Start on a discharge tick so the first discharge period is whole, not clipped.
            BLPD_IDLE:
                if (light_enable_flag && dis_tick) next_state = BLPD_PRE_DIS;
            BLPD_PRE_DIS:
                if (dis_wrap) next_state = light_enable_flag ? BLPD_PUMP : BLPD_IDLE;
            BLPD_PUMP:
                if (!light_enable_flag && pump_wrap) next_state = BLPD_POST_DIS;
            BLPD_POST_DIS:
                if (dis_wrap) next_state = light_enable_flag ? BLPD_PRE_DIS : BLPD_IDLE;
            default:
                next_state = BLPD_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state <= BLPD_IDLE;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs. Pins are released to their other roles unless the
    // backlight option is strapped, and both outputs stay low when idle.

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pump_clock_out      <= 1'b0;
            discharge_pulse_out <= 1'b0;
            port_select_out     <= 1'b0;
        end else begin
            port_select_out     <= option_sync;
            // Pumping only in the pump state, so it never overlaps a discharge.
            pump_clock_out      <= option_sync && state == BLPD_PUMP && pump_level;
            discharge_pulse_out <= option_sync && dis_level &&
                                   (state == BLPD_PRE_DIS || state == BLPD_POST_DIS);
        end
    end

endmodule // blpd_driver

/* File: pkg/blpd_cfg.svh */
`ifndef BLPD_CFG_SVH
`define BLPD_CFG_SVH

// Configuration word field positions.
`define BLPD_PUMP_FREQ_MSB   8
`define BLPD_PUMP_FREQ_LSB   6
`define BLPD_PUMP_DUTY_MSB   5
`define BLPD_PUMP_DUTY_LSB   4
`define BLPD_DIS_RATE_MSB    3
`define BLPD_DIS_RATE_LSB    2
`define BLPD_DIS_DUTY_MSB    1
`define BLPD_DIS_DUTY_LSB    0
`define BLPD_CFG_WIDTH       9

// Pumping clock frequency codes.
`define BLPD_PF_TAP0         3'h0
`define BLPD_PF_BASE         3'h4
`define BLPD_PF_BASE_DIV2    3'h5
`define BLPD_PF_BASE_DIV4    3'h6
`define BLPD_PF_BASE_DIV8    3'h7

// Duty codes shared by both waveforms.
`define BLPD_DUTY_QUARTER    2'h0
`define BLPD_DUTY_THIRD      2'h1
`define BLPD_DUTY_HALF       2'h2
`define BLPD_DUTY_FULL       2'h3

// Reset configuration: tap 0 quarter duty, tap 8 quarter duty.
`define BLPD_CFG_RESET       9'h000

// Flag operand that addresses the light-enable flag.
`define BLPD_LIGHT_OPERAND   4'h4

// APB register byte addresses.
`define BLPD_ADDR_CONFIG     12'h000
`define BLPD_ADDR_FLAG_SET   12'h004
`define BLPD_ADDR_FLAG_RESET 12'h008
`define BLPD_ADDR_STATUS     12'h00C

// Pre-divider: tap N toggles every 2^N system cycles (tap 0 is a half-rate enable).
`define BLPD_PREDIV_WIDTH    10

`endif

/* File: pkg/blpd_pkg.sv */
package blpd_pkg;

    // Driver sequencing states.
    typedef enum logic [3:0] {
        BLPD_IDLE     = 4'b0001,
        BLPD_PRE_DIS  = 4'b0010,
        BLPD_PUMP     = 4'b0100,
        BLPD_POST_DIS = 4'b1000
    } blpd_state_t;

    // APB request carrier.
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } blpd_apb_req_t;

    // APB answer carrier.
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } blpd_apb_rsp_t;

    // Decoded waveform configuration.
    typedef struct packed {
        logic [2:0] pump_freq;
        logic [1:0] pump_duty;
        logic [1:0] dis_rate;
        logic [1:0] dis_duty;
    } blpd_cfg_t;

endpackage

/* File: testbench/blpd_panel_model.sv */
`timescale 1ns/1ns
// Pump network and panel as seen from the pins; it also makes the base clock.
module blpd_panel_model #(
    parameter int BCLK_HALF = 4
) (
    input  wire logic sys_clk_in,
    input  wire logic pump_in,
    input  wire logic discharge_in,
    output logic      base_clock_out,
    output int        charge_out
);
    int   half_cnt;
    logic pump_d;
    initial begin
        half_cnt = 0;
        pump_d = 1'b0;
        charge_out = 0;
        base_clock_out = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // The base clock runs free off the system clock, so sub-step spacing is exact.
    always @(posedge sys_clk_in) begin
        half_cnt <= (half_cnt == BCLK_HALF - 1) ? 0 : half_cnt + 1;
        if (half_cnt == BCLK_HALF - 1) begin
            base_clock_out <= ~base_clock_out;
        end
    end
    // Each pump clock adds charge; a discharge pulse empties the panel.
    always @(posedge sys_clk_in) begin
        pump_d <= pump_in;
        if (discharge_in === 1'b1) begin
            charge_out <= 0;
        end else if (pump_in === 1'b1 && pump_d !== 1'b1) begin
            charge_out <= charge_out + 1;
        end
    end
endmodule // blpd_panel_model

/* File: testbench/blpd_driver_sva.sv */
`timescale 1ns/1ns
`include "blpd_cfg.svh"
module blpd_driver_sva
    import blpd_pkg::*;
(
    input wire logic          sys_clk_in,
    input wire logic          resetn_in,
    input wire blpd_apb_req_t apb_req_in,
    input wire logic          backlight_option_in,
    input wire blpd_apb_rsp_t apb_rsp_out,
    input wire logic          pump_clock_out,
    input wire logic          discharge_pulse_out,
    input wire logic          port_select_out
);
    logic acc;
    logic set_hit;
    logic set_seen;
    logic dis_seen;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    ////////////////////////////////////////////////////////////////
    // A completed access, and a write that switches the light on.
    assign acc = apb_req_in.psel & apb_req_in.penable & apb_rsp_out.pready;
    assign set_hit = acc & apb_req_in.pwrite & (apb_req_in.paddr == `BLPD_ADDR_FLAG_SET)
                     & (apb_req_in.pwdata[3:0] == `BLPD_LIGHT_OPERAND);
    // History since reset; never cleared, so it only catches a missing first discharge.
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            set_seen <= 1'b0;
            dis_seen <= 1'b0;
        end else begin
            set_seen <= set_seen | set_hit;
            dis_seen <= dis_seen | discharge_pulse_out;
        end
    end
    ////////////////////////////////////////////////////////////////
    a_no_overlap: assert property (!(pump_clock_out && discharge_pulse_out))
        else $error("pump and discharge high together");
    a_idle_before_set: assert property (!set_seen |-> !pump_clock_out && !discharge_pulse_out)
        else $error("output active before light enable");
    a_dis_first: assert property ($rose(pump_clock_out) |-> dis_seen)
        else $error("pump clock before any discharge");
    a_option_gate: assert property (!port_select_out && !$past(port_select_out)
        |-> !pump_clock_out && !discharge_pulse_out)
        else $error("outputs active with pin option off");
    a_option_follow: assert property ($rose(backlight_option_in) |-> ##[1:4] port_select_out)
        else $error("port select did not follow option");
    a_zero_wait: assert property (apb_req_in.psel && !apb_req_in.penable |=> apb_rsp_out.pready)
        else $error("pready missing in access cycle");
    a_ready_pulse: assert property (apb_rsp_out.pready |=> !apb_rsp_out.pready)
        else $error("pready longer than one cycle");
    a_unmapped_err: assert property (acc |-> apb_rsp_out.pslverr == (apb_req_in.paddr > `BLPD_ADDR_STATUS))
        else $error("pslverr wrong for address");
    a_flag_reads_zero: assert property (acc && !apb_req_in.pwrite && (apb_req_in.paddr == `BLPD_ADDR_FLAG_SET
        || apb_req_in.paddr == `BLPD_ADDR_FLAG_RESET) |-> apb_rsp_out.prdata == 32'h0)
        else $error("flag register read not zero");
    c_pump: cover property ($rose(pump_clock_out));
    c_discharge: cover property ($rose(discharge_pulse_out));
    c_slverr: cover property (acc && apb_rsp_out.pslverr);
endmodule // blpd_driver_sva
bind blpd_driver blpd_driver_sva sva_u (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .apb_req_in(apb_req_in),
    .backlight_option_in(backlight_option_in), .apb_rsp_out(apb_rsp_out), .pump_clock_out(pump_clock_out),
    .discharge_pulse_out(discharge_pulse_out), .port_select_out(port_select_out));

/* File: testbench/testbench.sv */
`timescale 1ns/1ns
`include "blpd_cfg.svh"
module testbench
    import blpd_pkg::*;
();
    typedef struct {blpd_cfg_t cfg; int pump_hi; int win; int dis_hi;} blpd_row_t;
    // Config, pump high cycles over ten periods, window length, discharge high cycles in one period.
    blpd_row_t rows [5] = '{'{9'h000, 60, 240, 1536}, '{9'h11D, 320, 960, 256}, '{9'h16A, 960, 1920, 768},
                            '{9'h1B7, 3840, 3840, 3072}, '{9'h1CC, 1920, 7680, 192}};
    logic          sys_clk = 1'b0;
    logic          resetn;
    logic          option;
    logic          bclk;
    logic          pump;
    logic          dis;
    logic          sel;
    blpd_apb_req_t req;
    blpd_apb_rsp_t rsp;
    int            charge;
    int            n_fail = 0;
    int            n_tests = 0;
    always #20 sys_clk = ~sys_clk;
    blpd_driver dut_u (.sys_clk_in(sys_clk), .resetn_in(resetn), .apb_req_in(req), .backlight_option_in(option),
        .base_clock_in(bclk), .apb_rsp_out(rsp), .pump_clock_out(pump), .discharge_pulse_out(dis),
        .port_select_out(sel));
    blpd_panel_model #(.BCLK_HALF(4)) panel_u (.sys_clk_in(sys_clk), .pump_in(pump), .discharge_in(dis),
        .base_clock_out(bclk), .charge_out(charge));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("[FAIL] %s expected %0h seen %0h", n, e, g);
            n_fail++;
        end
    endtask
    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int k;
        k = 0;
        @(posedge sys_clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        @(posedge sys_clk);
        while (rsp.pready !== 1'b1 && k < 20) begin
            @(posedge sys_clk);
            k++;
        end
        if (k == 20) chk("pready", 1, 0);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req <= '0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic        e;
        apb(1'b1, a, d, x, e);
    endtask
    task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] ex);
        logic [31:0] x;
        logic        e;
        apb(1'b0, a, 32'h0, x, e);
        chk(n, ex, x);
    endtask
    // Polls status until idle; a bounded count keeps a stuck driver from hanging the run.
    task automatic wait_idle(input logic [31:0] ex);
        logic [31:0] x;
        logic        e;
        int          k;
        k = 0;
        do begin
            apb(1'b0, `BLPD_ADDR_STATUS, 32'h0, x, e);
            k++;
        end while (x[3:0] !== 4'h1 && k < 9000);
        chk("status", ex, x);
    endtask
    task automatic results;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        #4000000;
        chk("watchdog", 0, 1);
        results;
    end
    initial begin
        logic [31:0] x;
        logic        e;
        int          i;
        int          k;
        int          c;
        req = '0;
        option = 1'b1;
        resetn = 1'b0;
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        rdchk("config", `BLPD_ADDR_CONFIG, 32'h0);
        rdchk("status", `BLPD_ADDR_STATUS, 32'h21);
        chk("select", 1, sel);
        apb(1'b0, 12'h010, 32'h0, x, e);
        chk("pslverr", 1, e);
        wr(`BLPD_ADDR_FLAG_SET, 32'h5);
        rdchk("status", `BLPD_ADDR_STATUS, 32'h21);
        // Row 0 runs on the reset configuration.
        for (i = 0; i < 5; i++) begin
            if (i > 0) wr(`BLPD_ADDR_CONFIG, 32'(rows[i].cfg));
            wr(`BLPD_ADDR_FLAG_SET, 32'h4);
            c = 0;
            k = 0;
            while (pump !== 1'b1 && k < 20000) begin
                c += (dis === 1'b1);
                @(posedge sys_clk);
                k++;
            end
            chk("dis_hi", rows[i].dis_hi, c);
            c = 0;
            repeat (rows[i].win) begin
                c += (pump === 1'b1);
                @(posedge sys_clk);
            end
            chk("pump_hi", rows[i].pump_hi, c);
            wr(`BLPD_ADDR_FLAG_RESET, 32'h4);
            wait_idle(32'h21);
            chk("charge", 0, charge);
        end
        option <= 1'b0;
        wr(`BLPD_ADDR_FLAG_SET, 32'h4);
        c = 0;
        repeat (8000) begin
            c += ((pump | dis) === 1'b1);
            @(posedge sys_clk);
        end
        chk("gated", 0, c);
        chk("select", 0, sel);
        wr(`BLPD_ADDR_FLAG_RESET, 32'h4);
        wait_idle(32'h01);
        option <= 1'b1;
        // Reset in mid-pump must drop the outputs and restore the default setting.
        wr(`BLPD_ADDR_FLAG_SET, 32'h4);
        repeat (2000) @(posedge sys_clk);
        resetn <= 1'b0;
        @(posedge sys_clk);
        @(posedge sys_clk);
        chk("reset_out", 0, {pump, dis});
        resetn <= 1'b1;
        rdchk("config", `BLPD_ADDR_CONFIG, 32'h0);
        rdchk("status", `BLPD_ADDR_STATUS, 32'h21);
        results;
    end
endmodule // testbench
